/* logic/dlirq_enable.sv */
// Interrupt enable, latched status and interrupt output of the first data link
// controller pair. Assumes event inputs are one-cycle pulses on clk.
//
// Functional notes
// - Bit 6 enable, reset 0, gates transmit message start interrupt.
// - Bit 5 enable, reset 0, gates receive message start interrupt.
// - Bit 4 enable, reset 0, gates transmit message end interrupt.
// - Bit 3 enable, reset 0, gates receive message end interrupt.
// - Bit 2 enable, reset 0, gates checksum error interrupt.
// - Bit 0 enable, reset 0, gates idle flag octet interrupt.
// - Events latch in status bits at same position; status read clears them.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "dlirq_consts.svh"

module dlirq_enable
  import dlirq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic txMsgStartEvent,
  input wire logic rxMsgStartEvent,
  input wire logic txMsgEndEvent,
  input wire logic rxMsgEndEvent,
  input wire logic checksumErrorEvent,
  input wire logic abortSeenEvent,
  input wire logic flagSeenEvent,
  input wire logic msgTypeIsMos,
  output logic irqOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic selStatus = regAddr == `DLIRQ_OFS_STATUS;
  wire logic selEnable = regAddr == `DLIRQ_OFS_ENABLE;
  wire logic selIrqSt = regAddr == `DLIRQ_OFS_IRQST;
  wire logic wrEnable = regWrStb && selEnable;
  wire logic rdStatus = regRdStb && selStatus;

  dlirq_evt_t enable_q;
  dlirq_evt_t status_q;
  dlirq_evt_t status_d;
  dlirq_byte_t rdData_d;
  logic msgType_q;
  logic irq_q;

  // Event vector in status bit order
  wire dlirq_evt_t events = {txMsgStartEvent, rxMsgStartEvent, txMsgEndEvent,
                             rxMsgEndEvent, checksumErrorEvent, abortSeenEvent,
                             flagSeenEvent};

  ////////////////////////////////////////////////////////////////////////////
  // Enable register
  // Bit 7 dropped on write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q <= `DLIRQ_ENABLE_RST;
    end else if (wrEnable) begin
      enable_q <= regWrData[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status
  // Set wins over read clear, so no event is lost
  assign status_d = (rdStatus ? `DLIRQ_STATUS_RST : status_q) | events;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= `DLIRQ_STATUS_RST;
      msgType_q <= `DLIRQ_MSGTYPE_RST;
    end else begin
      status_q <= status_d;
      msgType_q <= msgTypeIsMos;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating
  // Enable after this edge, so a mask write and the pin move together
  dlirq_evt_t enable_d;
  assign enable_d = wrEnable ? regWrData[6:0] : enable_q;

  wire logic gateTxStart = status_d[`DLIRQ_BIT_TXSTART] && enable_d[`DLIRQ_BIT_TXSTART];
  wire logic gateRxStart = status_d[`DLIRQ_BIT_RXSTART] && enable_d[`DLIRQ_BIT_RXSTART];
  wire logic gateTxEnd = status_d[`DLIRQ_BIT_TXEND] && enable_d[`DLIRQ_BIT_TXEND];
  wire logic gateRxEnd = status_d[`DLIRQ_BIT_RXEND] && enable_d[`DLIRQ_BIT_RXEND];
  wire logic gateCkErr = status_d[`DLIRQ_BIT_CKERR] && enable_d[`DLIRQ_BIT_CKERR];
  wire logic gateAbort = status_d[`DLIRQ_BIT_ABORT] && enable_d[`DLIRQ_BIT_ABORT];
  wire logic gateFlag = status_d[`DLIRQ_BIT_FLAG] && enable_d[`DLIRQ_BIT_FLAG];

  wire dlirq_evt_t pending = status_q & enable_q;
  // Registered so the pin is glitch free; moves on the same edge as status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= gateTxStart | gateRxStart | gateTxEnd | gateRxEnd |
               gateCkErr | gateAbort | gateFlag;
    end
  end
  assign irqOut = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // Reserved bit reads zero
  assign rdData_d = selStatus ? {msgType_q, status_q} :
                    selEnable ? {1'b0, enable_q} :
                    selIrqSt ? {1'b0, pending} : 8'h00;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRdStb ? rdData_d : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Event latches and survives a same-cycle read
  evt_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    txMsgStartEvent |=> status_q[`DLIRQ_BIT_TXSTART]) else $error("tx start not latched");
  read_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStatus && !flagSeenEvent) |=> !status_q[`DLIRQ_BIT_FLAG]) else $error("read did not clear");
  hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (status_q[`DLIRQ_BIT_ABORT] && !rdStatus) |=> status_q[`DLIRQ_BIT_ABORT])
    else $error("status dropped without read");

  sequence enTxEnd_s;
    enable_q[`DLIRQ_BIT_TXEND] && txMsgEndEvent && !wrEnable;
  endsequence
  // Enabled event raises interrupt next cycle
  tx_end_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    enTxEnd_s |=> irqOut) else $error("tx end irq missing");
  tx_start_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    (enable_q[`DLIRQ_BIT_TXSTART] && txMsgStartEvent && !wrEnable) |=> irqOut)
    else $error("tx start irq missing");
  masked_a: assert property (@(posedge clk) disable iff (sys_rst)
    enable_q == 7'h00 |-> !irqOut) else $error("irq with all disabled");
  // Disabled error alone gives no interrupt
  ckerr_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    (status_q == (7'h01 << `DLIRQ_BIT_CKERR) && !enable_q[`DLIRQ_BIT_CKERR]) |-> !irqOut)
    else $error("masked bits raised irq");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regRdStb && selEnable) |=> !regRdData[7]) else $error("reserved bit nonzero");
  en_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrEnable |=> enable_q == $past(regWrData[6:0])) else $error("enable not written");

  ////////////////////////////////////////////////////////////////////////////
  // Enabled events raise the pin

  sequence enRxStart_s;
    enable_q[`DLIRQ_BIT_RXSTART] && rxMsgStartEvent && !wrEnable;
  endsequence
  rx_start_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    enRxStart_s |=> irqOut)
    else $error("rx start irq missing");

  sequence enRxEnd_s;
    enable_q[`DLIRQ_BIT_RXEND] && rxMsgEndEvent && !wrEnable;
  endsequence
  rx_end_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    enRxEnd_s |=> irqOut)
    else $error("rx end irq missing");

  sequence enCkErr_s;
    enable_q[`DLIRQ_BIT_CKERR] && checksumErrorEvent && !wrEnable;
  endsequence
  ckerr_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    enCkErr_s |=> irqOut)
    else $error("checksum irq missing");

  sequence enAbort_s;
    enable_q[`DLIRQ_BIT_ABORT] && abortSeenEvent && !wrEnable;
  endsequence
  abort_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    enAbort_s |=> irqOut)
    else $error("abort irq missing");

  sequence enFlag_s;
    enable_q[`DLIRQ_BIT_FLAG] && flagSeenEvent && !wrEnable;
  endsequence
  flag_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    enFlag_s |=> irqOut)
    else $error("flag irq missing");

  ////////////////////////////////////////////////////////////////////////////
  // Disabled events stay off the pin

  sequence offTxStart_s;
    !enable_q[`DLIRQ_BIT_TXSTART] && !wrEnable && status_q == 7'h00 &&
      events == (7'h01 << `DLIRQ_BIT_TXSTART);
  endsequence
  tx_start_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    offTxStart_s |=> !irqOut)
    else $error("masked tx start raised irq");

  sequence offRxStart_s;
    !enable_q[`DLIRQ_BIT_RXSTART] && !wrEnable && status_q == 7'h00 &&
      events == (7'h01 << `DLIRQ_BIT_RXSTART);
  endsequence
  rx_start_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    offRxStart_s |=> !irqOut)
    else $error("masked rx start raised irq");

  sequence offTxEnd_s;
    !enable_q[`DLIRQ_BIT_TXEND] && !wrEnable && status_q == 7'h00 &&
      events == (7'h01 << `DLIRQ_BIT_TXEND);
  endsequence
  tx_end_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    offTxEnd_s |=> !irqOut)
    else $error("masked tx end raised irq");

  sequence offRxEnd_s;
    !enable_q[`DLIRQ_BIT_RXEND] && !wrEnable && status_q == 7'h00 &&
      events == (7'h01 << `DLIRQ_BIT_RXEND);
  endsequence
  rx_end_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    offRxEnd_s |=> !irqOut)
    else $error("masked rx end raised irq");

  sequence offCkErr_s;
    !enable_q[`DLIRQ_BIT_CKERR] && !wrEnable && status_q == 7'h00 &&
      events == (7'h01 << `DLIRQ_BIT_CKERR);
  endsequence
  ckerr_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    offCkErr_s |=> !irqOut)
    else $error("masked checksum raised irq");

  sequence offAbort_s;
    !enable_q[`DLIRQ_BIT_ABORT] && !wrEnable && status_q == 7'h00 &&
      events == (7'h01 << `DLIRQ_BIT_ABORT);
  endsequence
  abort_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    offAbort_s |=> !irqOut)
    else $error("masked abort raised irq");

  sequence offFlag_s;
    !enable_q[`DLIRQ_BIT_FLAG] && !wrEnable && status_q == 7'h00 &&
      events == (7'h01 << `DLIRQ_BIT_FLAG);
  endsequence
  flag_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    offFlag_s |=> !irqOut)
    else $error("masked flag raised irq");

  ////////////////////////////////////////////////////////////////////////////
  // Status, pending and pin consistency

  irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    irqOut == |(status_q & enable_q))
    else $error("irq level wrong");

  all_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    (events != 7'h00) |=> (status_q & $past(events)) == $past(events))
    else $error("event not latched");

  // Read with no event drops the pin
  irq_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStatus && events == 7'h00) |=> !irqOut)
    else $error("irq stayed after read");

  status_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    rdStatus |=> regRdData == {$past(msgType_q), $past(status_q)})
    else $error("status read data wrong");

  pending_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regRdStb && selIrqSt) |=> regRdData == {1'b0, $past(pending)})
    else $error("pending read data wrong");

  status_nowr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regWrStb && selStatus && events == 7'h00) |=> status_q == $past(status_q))
    else $error("status changed by write");

  rsvd_no_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wrEnable && regWrData[6:0] == 7'h00) |=> !irqOut)
    else $error("reserved bit raised irq");

  en_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wrEnable |=> enable_q == $past(enable_q))
    else $error("enable changed without write");

endmodule : dlirq_enable

/* logic/dlirq_consts.svh */
// Offsets, field positions and reset values of the data link interrupt block.
// Assumes byte-wide registers on a plain strobe port.
`ifndef DLIRQ_CONSTS_SVH
`define DLIRQ_CONSTS_SVH
`define DLIRQ_ADDR_W 4
`define DLIRQ_OFS_STATUS 4'h0
`define DLIRQ_OFS_ENABLE 4'h1
`define DLIRQ_OFS_EVMASK 4'h2
`define DLIRQ_OFS_IRQST 4'h3
`define DLIRQ_BIT_TXSTART 6
`define DLIRQ_BIT_RXSTART 5
`define DLIRQ_BIT_TXEND 4
`define DLIRQ_BIT_RXEND 3
`define DLIRQ_BIT_CKERR 2
`define DLIRQ_BIT_ABORT 1
`define DLIRQ_BIT_FLAG 0
`define DLIRQ_EVT_W 7
`define DLIRQ_ENABLE_RST 7'h00
`define DLIRQ_STATUS_RST 7'h00
`define DLIRQ_MSGTYPE_RST 1'b0
`define DLIRQ_FLAG_OCTET 8'h7E
`endif

/* logic/dlirq_pkg.sv */
// Types shared by the data link interrupt block.
// Assumes dlirq_consts.svh is compiled alongside.
package dlirq_pkg;
  typedef logic [7:0] dlirq_byte_t;
  typedef logic [6:0] dlirq_evt_t;
endpackage : dlirq_pkg

/* testbench/tb_dlirq_enable.sv */
// Bench for the data link interrupt enable block.
// Assumes the strobe register port and one-cycle event pulses on clk.
`timescale 1ns/1ps
`include "dlirq_consts.svh"
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin errCount++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end

module tb_dlirq_enable;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [7:0] regRdData;
  logic [6:0] evt = 7'h00;
  logic msgTypeIsMos = 1'b0;
  logic irqOut;
  int errCount = 0;
  int totalChecks = 0;
  int cycles = 0;

  dlirq_enable dlirq_enable_i (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .txMsgStartEvent(evt[`DLIRQ_BIT_TXSTART]),
    .rxMsgStartEvent(evt[`DLIRQ_BIT_RXSTART]), .txMsgEndEvent(evt[`DLIRQ_BIT_TXEND]),
    .rxMsgEndEvent(evt[`DLIRQ_BIT_RXEND]), .checksumErrorEvent(evt[`DLIRQ_BIT_CKERR]),
    .abortSeenEvent(evt[`DLIRQ_BIT_ABORT]), .flagSeenEvent(evt[`DLIRQ_BIT_FLAG]),
    .msgTypeIsMos(msgTypeIsMos), .irqOut(irqOut));

  initial begin
    forever #5 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      endSim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic endSim();
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : endSim

  task automatic wr(input logic [3:0] a, input dlirq_pkg::dlirq_byte_t d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rdChk(input logic [3:0] a, input dlirq_pkg::dlirq_byte_t e);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask : rdChk

  task automatic pulse(input logic [6:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 7'h00;
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    `CHK(irqOut, 1'b0)
    rdChk(`DLIRQ_OFS_ENABLE, 8'h00);
    rdChk(`DLIRQ_OFS_STATUS, 8'h00);
    wr(`DLIRQ_OFS_ENABLE, 8'hFF);
    rdChk(`DLIRQ_OFS_ENABLE, 8'h7F);
    for (int i = 0; i < 7; i++) begin
      wr(`DLIRQ_OFS_ENABLE, 8'h01 << i);
      pulse(7'h01 << i);
      `CHK(irqOut, 1'b1)
      rdChk(`DLIRQ_OFS_STATUS, 8'h01 << i);
      `CHK(irqOut, 1'b0)
      wr(`DLIRQ_OFS_ENABLE, 8'h7F ^ (8'h01 << i));
      pulse(7'h01 << i);
      `CHK(irqOut, 1'b0)
      rdChk(`DLIRQ_OFS_STATUS, 8'h01 << i);
      rdChk(`DLIRQ_OFS_STATUS, 8'h00);
    end
    wr(`DLIRQ_OFS_ENABLE, 8'h05);
    pulse(7'h07);
    `CHK(irqOut, 1'b1)
    rdChk(`DLIRQ_OFS_IRQST, 8'h05);
    rdChk(`DLIRQ_OFS_STATUS, 8'h07);
    wr(`DLIRQ_OFS_ENABLE, 8'h80);
    wr(`DLIRQ_OFS_STATUS, 8'hFF);
    pulse(7'h7F);
    `CHK(irqOut, 1'b0)
    @(posedge clk);
    msgTypeIsMos <= 1'b1;
    rdChk(`DLIRQ_OFS_STATUS, 8'hFF);
    rdChk(`DLIRQ_OFS_EVMASK, 8'h00);
    endSim();
  end
endmodule : tb_dlirq_enable
